// ==== rtl/lcg_pkg.sv ====
// shared constants and types of the display command interpreter
package lcg_pkg;
   // command codes held in the instruction register
   localparam logic [3:0] LCG_CMD_MODE       = 4'h0;
   localparam logic [3:0] LCG_CMD_PITCH      = 4'h1;
   localparam logic [3:0] LCG_CMD_CHARS      = 4'h2;
   localparam logic [3:0] LCG_CMD_DUTY       = 4'h3;
   localparam logic [3:0] LCG_CMD_CURSOR_LN  = 4'h4;
   localparam logic [3:0] LCG_CMD_START_LO   = 4'h8;
   localparam logic [3:0] LCG_CMD_START_HI   = 4'h9;
   localparam logic [3:0] LCG_CMD_CURSOR_LO  = 4'hA;
   localparam logic [3:0] LCG_CMD_CURSOR_HI  = 4'hB;
   localparam logic [3:0] LCG_CMD_WRITE      = 4'hC;
   localparam logic [3:0] LCG_CMD_READ       = 4'hD;
   localparam logic [3:0] LCG_CMD_BIT_CLEAR  = 4'hE;
   localparam logic [3:0] LCG_CMD_BIT_SET    = 4'hF;
   // field positions
   localparam int         LCG_BUSY_BIT       = 7;
   localparam int         LCG_HP_LSB         = 0;
   localparam int         LCG_VP_LSB         = 4;
   localparam logic [2:0] LCG_HP_CODE_MIN    = 3'h5;
   // values after reset
   localparam logic [3:0] LCG_RST_CMD        = 4'h0;
   localparam logic [3:0] LCG_RST_HP         = 4'h8;
   localparam logic [4:0] LCG_RST_VP         = 5'h08;
   localparam logic [8:0] LCG_RST_HN         = 9'h002;
   localparam logic [8:0] LCG_RST_NX         = 9'h040;
   localparam logic [4:0] LCG_RST_CP         = 5'h08;
   localparam logic [7:0] LCG_RST_MODE       = 8'h00;
   localparam logic [15:0] LCG_RST_ADDR      = 16'h0000;
   localparam logic [7:0] LCG_RST_OUT        = 8'h00;
   // execution time of one accepted data access
   localparam int         LCG_EXEC_NS        = 40;
   localparam int         LCG_CLK_NS         = 10;
   localparam int         LCG_EXEC_CYCLES    =
      (LCG_EXEC_NS + LCG_CLK_NS - 1) / LCG_CLK_NS;

   typedef enum logic [1:0] {
      st_idle, st_fetch, st_modify
   } lcg_state_type;

   typedef struct packed {
      logic       strobe;
      logic       register_select;
      logic       read_write_select;
      logic [7:0] data;
   } lcg_access_type;

   typedef struct packed {
      logic [7:0]  display_mode;
      logic [3:0]  horizontal_pitch;
      logic [8:0]  chars_per_line;
      logic [4:0]  vertical_pitch;
      logic [4:0]  cursor_line;
      logic [8:0]  duty_lines;
      logic [11:0] horizontal_dots;
      logic        cursor_visible;
      logic [15:0] display_start;
   } lcg_geometry_type;
endpackage : lcg_pkg

// ==== rtl/lcg_display_ram.sv ====
// display memory with one synchronous read and one write port
`timescale 1ns/100ps
`default_nettype none
module lcg_display_ram #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input  wire logic              clock,
   input  wire logic              write_en,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic [DATA_W-1:0] write_data,
   output var  logic [DATA_W-1:0] read_data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // read before write: a modify cycle sees the old byte
   always_ff @(posedge clock) begin
      read_data <= mem[address];
   end

   always_ff @(posedge clock) begin
      if (write_en) begin
         mem[address] <= write_data;
      end
   end
endmodule // lcg_display_ram
`default_nettype wire

// ==== rtl/lcg_exec_timer.sv ====
// execution timer that holds busy for a fixed number of cycles
`timescale 1ns/100ps
`default_nettype none
module lcg_exec_timer
   import lcg_pkg::*;
#(
   parameter int CYCLES = LCG_EXEC_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic start,
   output var  logic busy
);
   logic [7:0] count;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= 8'h00;
      end else if (start) begin
         count <= 8'(CYCLES);
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= start || (count > 8'h01);
      end
   end
endmodule // lcg_exec_timer
`default_nettype wire

// ==== rtl/lcg_command_core.sv ====
// Function
// [RULE1] read data: code selected in instruction register, then reads with select low
// [RULE2] data read outputs latch, refills it from cursor address, cursor steps
// [RULE3] host does one dummy read after loading the cursor address
// [RULE4] bit clear and bit set codes take one index byte, bits 7..3 zero
// [RULE5] bit op rewrites only the chosen bit of the addressed byte
// [RULE6] index zero picks the lsb, index seven the msb
// [RULE7] cursor steps by one when a bit op completes
// [RULE8] status read with select high returns busy on bit 7
// [RULE9] busy is high while any of the thirteen commands executes
// [RULE10] nothing is accepted while busy; host polls busy before writing
// [RULE11] host may skip polling once the longest cycle time has passed
// [RULE12] writing the instruction register leaves busy unchanged
// [RULE13] horizontal pitch 6 to 8; dots equal pitch times characters
// [RULE14] characters per line: even values 2 to 256 only
// [RULE15] vertical pitch 1 to 16; lines equal vertical dots over pitch
// [RULE16] cursor line 1 to 16, shown only when not above vertical pitch
// [RULE17] duty lines 1 to 256, reset to 64
// [RULE18] select high writes commands, select low writes parameters or data
// [RULE19] cursor is a 16-bit up counter, loaded low byte then high byte
// [RULE20] bit op with nonzero bits 7..3 leaves memory and cursor alone
`timescale 1ns/100ps
`default_nettype none
module lcg_command_core
   import lcg_pkg::*;
#(
   parameter int ADDR_W      = 16,
   parameter int EXEC_CYCLES = LCG_EXEC_CYCLES
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             access_strobe,
   input  wire logic             register_select,
   input  wire logic             read_write_select,
   input  wire logic [7:0]       bus_data_in,
   output var  logic [7:0]       bus_data_out,
   output var  logic             bus_data_oe,
   output var  logic             busy_flag,
   output var  logic [15:0]      cursor_address,
   output var  lcg_geometry_type geometry
);
   lcg_access_type acc;
   lcg_state_type  state;
   logic [3:0]     command;
   logic [7:0]     out_reg;
   logic [7:0]     ram_q;
   logic [7:0]     ram_wdata;
   logic           ram_we;
   logic           timer_busy;
   logic           busy;
   logic           take_cmd;
   logic           take_param;
   logic           take_read;
   logic           take_status;
   logic           bit_ok;
   logic           bit_cmd;
   logic [2:0]     bit_idx;
   logic           bit_val;

   // set or clear one bit of a byte
   function automatic logic [7:0] lcg_bit_apply(
      input logic [7:0] b,
      input logic [2:0] idx,
      input logic       set
   );
      logic [7:0] r;
      r = b;
      r[idx] = set;
      return r;
   endfunction

   // pitch times characters, at most 8 * 256
   function automatic logic [11:0] lcg_dots(
      input logic [3:0] hp,
      input logic [8:0] hn
   );
      return 12'(hp) * 12'(hn);
   endfunction

   assign acc = '{strobe: access_strobe,
                  register_select: register_select,
                  read_write_select: read_write_select,
                  data: bus_data_in};

   assign busy = timer_busy || (state != st_idle); // see [RULE9]

   always_comb begin
      take_cmd    = acc.strobe && acc.register_select
                    && !acc.read_write_select && !busy;
      take_status = acc.strobe && acc.register_select
                    && acc.read_write_select;
      take_param  = acc.strobe && !acc.register_select
                    && !acc.read_write_select && !busy;
      take_read   = acc.strobe && !acc.register_select
                    && acc.read_write_select && !busy
                    && (command == LCG_CMD_READ); // see [RULE1]
   end

   // a bit index byte with upper bits set is dropped
   assign bit_cmd = (command == LCG_CMD_BIT_CLEAR)
                    || (command == LCG_CMD_BIT_SET); // see [RULE4]
   assign bit_ok  = (acc.data[7:3] == 5'h00); // see [RULE20]

   lcg_exec_timer #(
      .CYCLES (EXEC_CYCLES)
   ) u_timer (
      .clock (clock),
      .rst   (rst),
      .start (take_param || take_read),
      .busy  (timer_busy)
   );

   always_comb begin
      ram_we    = 1'b0;
      ram_wdata = acc.data;
      if (state == st_modify) begin
         ram_we    = 1'b1;
         ram_wdata = lcg_bit_apply(ram_q, bit_idx, bit_val); // see [RULE5]
      end else if (take_param && command == LCG_CMD_WRITE) begin
         ram_we    = 1'b1;
      end
   end

   lcg_display_ram #(
      .ADDR_W (ADDR_W),
      .DATA_W (8)
   ) u_ram (
      .clock      (clock),
      .write_en   (ram_we),
      .address    (cursor_address[ADDR_W-1:0]),
      .write_data (ram_wdata),
      .read_data  (ram_q)
   );

   // instruction register; busy is not touched here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         command <= LCG_RST_CMD;
      end else if (take_cmd) begin
         command <= acc.data[3:0]; // see [RULE18] [RULE12] [RULE10]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state   <= st_idle;
         bit_idx <= 3'h0;
         bit_val <= 1'b0;
      end else begin
         case (state)
            st_idle: begin
               if (take_read) begin
                  state <= st_fetch;
               end else if (take_param && bit_cmd && bit_ok) begin
                  state   <= st_modify;
                  bit_idx <= acc.data[2:0]; // see [RULE6]
                  bit_val <= (command == LCG_CMD_BIT_SET);
               end
            end
            st_fetch: begin
               state <= st_idle;
            end
            st_modify: begin
               state <= st_idle;
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // data output latch is refilled after each read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_reg <= LCG_RST_OUT;
      end else if (state == st_fetch) begin
         out_reg <= ram_q; // see [RULE2] [RULE3]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cursor_address <= LCG_RST_ADDR;
      end else if (state == st_fetch || state == st_modify) begin
         cursor_address <= cursor_address + 16'h0001; // see [RULE2] [RULE7]
      end else if (take_param) begin
         if (command == LCG_CMD_WRITE) begin
            cursor_address <= cursor_address + 16'h0001;
         end else if (command == LCG_CMD_CURSOR_LO) begin
            cursor_address[7:0] <= acc.data; // see [RULE19]
         end else if (command == LCG_CMD_CURSOR_HI) begin
            cursor_address[15:8] <= acc.data; // see [RULE19]
         end
      end
   end

   // bus answers; the pin enable follows read_write_select one cycle late, strobe or not
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_data_out <= 8'h00;
      end else if (take_status) begin
         bus_data_out <= 8'h00;
         bus_data_out[LCG_BUSY_BIT] <= busy; // see [RULE8]
      end else if (take_read) begin
         bus_data_out <= out_reg; // see [RULE2]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_data_oe <= 1'b0;
      end else begin
         bus_data_oe <= read_write_select;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= busy;
      end
   end

   // screen setup values and the figures derived from them;
   // one process, so the geometry struct has a single driver
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         geometry.display_mode     <= LCG_RST_MODE;
         geometry.horizontal_pitch <= LCG_RST_HP;
         geometry.vertical_pitch   <= LCG_RST_VP;
         geometry.chars_per_line   <= LCG_RST_HN;
         geometry.duty_lines       <= LCG_RST_NX; // see [RULE17]
         geometry.cursor_line      <= LCG_RST_CP;
         geometry.display_start    <= LCG_RST_ADDR;
         geometry.horizontal_dots  <= lcg_dots(LCG_RST_HP, LCG_RST_HN);
         geometry.cursor_visible   <= 1'b1;
      end else begin
         // derived figures lag a setup write by one cycle
         geometry.horizontal_dots <= lcg_dots(geometry.horizontal_pitch,
            geometry.chars_per_line); // see [RULE13]
         geometry.cursor_visible  <= (geometry.cursor_line
            <= geometry.vertical_pitch); // see [RULE16]
         // out of range fields are ignored; a pitch byte still sets the vertical pitch
         if (take_param) begin
            if (command == LCG_CMD_MODE) begin
               geometry.display_mode <= acc.data;
            end else if (command == LCG_CMD_PITCH) begin
               if (acc.data[LCG_HP_LSB+:3] >= LCG_HP_CODE_MIN) begin
                  geometry.horizontal_pitch <=
                     {1'b0, acc.data[LCG_HP_LSB+:3]} + 4'h1; // see [RULE13]
               end
               geometry.vertical_pitch <=
                  {1'b0, acc.data[LCG_VP_LSB+:4]} + 5'h01; // see [RULE15]
            end else if (command == LCG_CMD_CHARS) begin
               if (acc.data[0]) begin
                  geometry.chars_per_line <=
                     {1'b0, acc.data} + 9'h001; // see [RULE14]
               end
            end else if (command == LCG_CMD_DUTY) begin
               geometry.duty_lines <=
                  {1'b0, acc.data} + 9'h001; // see [RULE17]
            end else if (command == LCG_CMD_CURSOR_LN) begin
               if (acc.data[7:4] == 4'h0) begin
                  geometry.cursor_line <=
                     {1'b0, acc.data[3:0]} + 5'h01; // see [RULE16]
               end
            end else if (command == LCG_CMD_START_LO) begin
               geometry.display_start[7:0] <= acc.data;
            end else if (command == LCG_CMD_START_HI) begin
               geometry.display_start[15:8] <= acc.data;
            end
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_READ_REFILL: assert property ( // see [RULE2]
      take_read |=> state == st_fetch ##1 out_reg == $past(ram_q)
   ) else $error("read did not refill the output latch");

   AST_READ_OUT: assert property ( // see [RULE2]
      take_read |=> bus_data_out == $past(out_reg)
   ) else $error("read did not return the old latch");

   AST_READ_STEP: assert property ( // see [RULE2]
      take_read |-> ##2 cursor_address == $past(cursor_address, 2) + 16'h1
   ) else $error("read did not step the cursor");

   AST_BIT_RMW: assert property ( // see [RULE5] [RULE6]
      state == st_modify |-> ram_we
         && ram_wdata[bit_idx] == bit_val
         && (ram_wdata ^ ram_q) == ((ram_q[bit_idx] ^ bit_val) << bit_idx)
   ) else $error("bit op touched other bits");

   AST_BIT_STEP: assert property ( // see [RULE7]
      state == st_modify |=> cursor_address == $past(cursor_address) + 16'h1
   ) else $error("bit op did not step the cursor");

   AST_BIT_BAD: assert property ( // see [RULE20]
      take_param && bit_cmd && !bit_ok |=> state == st_idle
         && cursor_address == $past(cursor_address)
   ) else $error("bad bit index was acted on");

   AST_STATUS: assert property ( // see [RULE8]
      take_status |=> bus_data_out[7] == $past(busy)
         && bus_data_out[6:0] == 7'h00
   ) else $error("status read lost busy");

   AST_BUSY_HOLD: assert property ( // see [RULE9]
      take_param || take_read |=> busy ##1 busy_flag
   ) else $error("busy not raised for a command");

   AST_CMD_NO_BUSY: assert property ( // see [RULE12]
      take_cmd && !busy |=> !busy
   ) else $error("command write changed busy");

   AST_REFUSE: assert property ( // see [RULE10]
      acc.strobe && !acc.read_write_select && busy |=>
         command == $past(command)
         && cursor_address == $past(cursor_address)
            + {15'h0000, $past(state) != st_idle}
   ) else $error("write accepted while busy");

   AST_DOTS: assert property ( // see [RULE13]
      $stable(geometry.horizontal_pitch) && $stable(geometry.chars_per_line)
      |=> geometry.horizontal_dots == 12'($past(geometry.horizontal_pitch))
         * 12'($past(geometry.chars_per_line))
   ) else $error("horizontal dot count wrong");

   AST_PITCH_RANGE: assert property ( // see [RULE13] [RULE15]
      geometry.horizontal_pitch inside {[4'h6:4'h8]}
         && geometry.vertical_pitch inside {[5'h01:5'h10]}
   ) else $error("pitch outside its range");

   AST_HN_EVEN: assert property ( // see [RULE14]
      geometry.chars_per_line[0] == 1'b0
   ) else $error("odd character count stored");

   COV_READ: cover property (take_read ##2 take_read);
   COV_SET: cover property (state == st_modify && bit_val);
   COV_CLR: cover property (state == st_modify && !bit_val);
   COV_BUSY_POLL: cover property (busy && take_status);
endmodule // lcg_command_core
`default_nettype wire

// ==== verification/lcg_host_model.sv ====
// host processor model that drives the controller's access pins
`timescale 1ns/100ps
`default_nettype none
module lcg_host_model
   import lcg_pkg::*;
(
   input  wire logic           clock,
   input  wire logic [7:0]     bus_data_out,
   output var  lcg_access_type host_access,
   output var  int             timeouts
);
   initial begin
      host_access = '{1'b0, 1'b1, 1'b0, 8'h00};
      timeouts    = 0;
   end

   // one strobe pulse; answer read a cycle late since the latch holds
   task automatic access(input logic rs, input logic rw,
                         input logic [7:0] din, output logic [7:0] dout);
      @(negedge clock);
      host_access = '{1'b1, rs, rw, din};
      @(negedge clock);
      host_access.strobe = 1'b0;
      // released data lines must not keep the last value
      host_access.data   = ~din;
      @(negedge clock);
      dout = bus_data_out;
   endtask

   // poll status before every instruction or data byte
   task automatic wait_ready();
      logic [7:0] st;
      int         n;
      n = 0;
      do begin
         access(1'b1, 1'b1, 8'h00, st);
         n++;
      end while (st[LCG_BUSY_BIT] !== 1'b0 && n < 64);
      if (n >= 64) timeouts++;
   endtask

   // command code in the low nibble
   task automatic write_cmd(input logic [3:0] code);
      logic [7:0] d;
      wait_ready();
      access(1'b1, 1'b0, {4'h0, code}, d);
   endtask

   task automatic write_data(input logic [7:0] b);
      logic [7:0] d;
      wait_ready();
      access(1'b0, 1'b0, b, d);
   endtask

   // caller checks the first read after a cursor load against the stale latch
   task automatic read_data(output logic [7:0] b);
      wait_ready();
      access(1'b0, 1'b1, 8'h00, b);
   endtask
endmodule // lcg_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the display command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import lcg_pkg::*;
;
   logic             clock;
   logic             rst;
   lcg_access_type   host_access;
   logic [7:0]       bus_data_out;
   logic             bus_data_oe;
   logic             busy_flag;
   logic [15:0]      cursor_address;
   lcg_geometry_type geometry;
   int               timeouts;
   int               errors;
   int               cmp_count;
   logic [7:0]       rd;

   lcg_host_model i_host (
      .clock        (clock),
      .bus_data_out (bus_data_out),
      .host_access  (host_access),
      .timeouts     (timeouts)
   );

   lcg_command_core i_dut (
      .clock             (clock),
      .rst               (rst),
      .access_strobe     (host_access.strobe),
      .register_select   (host_access.register_select),
      .read_write_select (host_access.read_write_select),
      .bus_data_in       (host_access.data),
      .bus_data_out      (bus_data_out),
      .bus_data_oe       (bus_data_oe),
      .busy_flag         (busy_flag),
      .cursor_address    (cursor_address),
      .geometry          (geometry)
   );

   always #5 clock = ~clock;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      errors += timeouts;
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic set_cursor(input logic [15:0] a);
      i_host.write_cmd(LCG_CMD_CURSOR_LO);
      i_host.write_data(a[7:0]);
      i_host.write_cmd(LCG_CMD_CURSOR_HI);
      i_host.write_data(a[15:8]);
   endtask

   // first eight bytes got one bit set, next eight one bit cleared
   function automatic logic [7:0] bit_exp(input int i);
      return (i < 8) ? (8'h01 << i) : ~(8'h01 << (i - 8));
   endfunction

   initial begin
      errors    = 0;
      cmp_count = 0;
      clock     = 1'b0;
      rst       = 1'b1;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      check(busy_flag, 16'h0000);
      check(bus_data_oe, 16'h0000);
      check(cursor_address, LCG_RST_ADDR);
      check(geometry.duty_lines, LCG_RST_NX);
      check(geometry.horizontal_dots, 16'h0010);
      i_host.write_cmd(LCG_CMD_WRITE);
      repeat (2) @(negedge clock);
      check(busy_flag, 16'h0000);
      check(bus_data_oe, 16'h0000);
      set_cursor(16'h12FF);
      check(cursor_address, 16'h12FF);
      i_host.write_cmd(LCG_CMD_WRITE);
      i_host.write_data(8'hA5);
      check(busy_flag, 16'h0001);
      // no poll on purpose: this byte arrives while busy
      i_host.access(1'b0, 1'b0, 8'h77, rd);
      i_host.write_data(8'h3C);
      i_host.access(1'b1, 1'b1, 8'h00, rd);
      check(rd[LCG_BUSY_BIT], 16'h0001);
      check(bus_data_oe, 16'h0001);
      i_host.wait_ready();
      check(cursor_address, 16'h1301);
      // the longest cycle time is let pass instead of polling
      i_host.write_data(8'h5A);
      repeat (LCG_EXEC_CYCLES) @(negedge clock);
      i_host.access(1'b0, 1'b0, 8'h6B, rd);
      i_host.wait_ready();
      check(cursor_address, 16'h1303);
      set_cursor(16'h0040);
      i_host.write_cmd(LCG_CMD_WRITE);
      for (int i = 0; i < 16; i++)
         i_host.write_data((i < 8) ? 8'h00 : 8'hFF);
      set_cursor(16'h0040);
      i_host.write_cmd(LCG_CMD_BIT_SET);
      for (int i = 0; i < 8; i++)
         i_host.write_data(8'(i));
      i_host.write_cmd(LCG_CMD_BIT_CLEAR);
      for (int i = 0; i < 8; i++)
         i_host.write_data(8'(i));
      i_host.wait_ready();
      check(cursor_address, 16'h0050);
      set_cursor(16'h0048);
      i_host.write_cmd(LCG_CMD_BIT_SET);
      i_host.write_data(8'h08);
      i_host.wait_ready();
      check(cursor_address, 16'h0048);
      set_cursor(16'h12FF);
      i_host.write_cmd(LCG_CMD_READ);
      i_host.read_data(rd);
      check(rd, LCG_RST_OUT);
      i_host.read_data(rd);
      check(rd, 16'h00A5);
      i_host.read_data(rd);
      check(rd, 16'h003C);
      set_cursor(16'h0040);
      i_host.write_cmd(LCG_CMD_READ);
      // dummy read hands back the byte fetched by the last stream
      i_host.read_data(rd);
      check(rd, 16'h005A);
      for (int i = 0; i < 16; i++) begin
         i_host.read_data(rd);
         check(rd, bit_exp(i));
      end
      check(cursor_address, 16'h0051);
      i_host.write_cmd(LCG_CMD_PITCH);
      i_host.write_data(8'h35);
      i_host.write_cmd(LCG_CMD_CHARS);
      i_host.write_data(8'h13);
      i_host.write_data(8'h14);
      i_host.write_cmd(LCG_CMD_CURSOR_LN);
      i_host.write_data(8'h05);
      i_host.write_cmd(LCG_CMD_DUTY);
      i_host.write_data(8'hFF);
      i_host.wait_ready();
      check(geometry.horizontal_pitch, 16'h0006);
      check(geometry.vertical_pitch, 16'h0004);
      check(geometry.chars_per_line, 16'h0014);
      check(geometry.horizontal_dots, 16'h0078);
      check(geometry.cursor_visible, 16'h0000);
      check(geometry.duty_lines, 16'h0100);
      i_host.write_cmd(LCG_CMD_CURSOR_LN);
      i_host.write_data(8'h03);
      i_host.wait_ready();
      check(geometry.cursor_line, 16'h0004);
      check(geometry.cursor_visible, 16'h0001);
      // pitch code below six dots keeps the old horizontal pitch
      i_host.write_cmd(LCG_CMD_PITCH);
      i_host.write_data(8'h22);
      i_host.write_cmd(LCG_CMD_MODE);
      i_host.write_data(8'h2C);
      i_host.write_cmd(LCG_CMD_START_LO);
      i_host.write_data(8'h34);
      i_host.write_cmd(LCG_CMD_START_HI);
      i_host.write_data(8'h12);
      i_host.wait_ready();
      check(geometry.horizontal_pitch, 16'h0006);
      check(geometry.vertical_pitch, 16'h0003);
      check(geometry.cursor_visible, 16'h0000);
      check(geometry.display_mode, 16'h002C);
      check(geometry.display_start, 16'h1234);
      test_done();
   end

   // whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
